// ==== dv/ccr_host_model.sv ====
// Host processor model acting as master on the two-wire bus
`default_nettype none
module ccr_host_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull,
	output logic got,
	output logic [7:0] got_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	import ccr_pkg::*;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		got = 1'b0;
		got_byte = 8'h00;
	end
	// Four-cycle phases keep both clock levels above the two-cycle minimum
	task automatic half();
		repeat (4) @(negedge clk);
	endtask
	task automatic bit_io(input logic b, output logic s);
		@(negedge clk) sda_pull = ~b;
		half();
		scl = 1'b1;
		half();
		s = sda;
		scl = 1'b0;
	endtask
	task automatic start();
		@(negedge clk) sda_pull = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_pull = 1'b1;
		half();
		scl = 1'b0;
	endtask
	task automatic stop();
		@(negedge clk) sda_pull = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_pull = 1'b0;
		half();
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic recv(input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			got_byte[i] = s;
		end
		got = 1'b1;
		bit_io(~ack, s);
		got = 1'b0;
	endtask
	task automatic write_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n, input logic [7:0] d [4],
		output logic [5:0] acks);
		start();
		send({dev, 1'b0}, acks[0]);
		send(ptr, acks[1]);
		for (int k = 0; k < n; k++) begin
			send(d[k], acks[k + 2]);
		end
		stop();
	endtask
	// Last byte is refused by the host so the device lets go before the stop
	task automatic read_regs(input logic [7:0] ptr, input int n, output logic [2:0] acks);
		start();
		send({CCR_SLAVE_ADDR, 1'b0}, acks[0]);
		send(ptr, acks[1]);
		start();
		send({CCR_SLAVE_ADDR, 1'b1}, acks[2]);
		for (int k = 0; k < n; k++) begin
			recv(k < n - 1);
		end
		stop();
	endtask
endmodule
`default_nettype wire

// ==== dv/ccr_regs_checker.sv ====
// Port-level assertions for the charger configuration register bank
`default_nettype none
module ccr_regs_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic watchdog_expired,
	input wire logic host_mode,
	input wire logic watchdog_kick,
	input wire logic register_reset_pulse,
	input wire logic [1:0] operating_mode_select,
	input wire logic charge_enable,
	input wire logic boost_enable,
	input wire logic [2:0] minimum_system_voltage_code,
	input wire logic boost_current_limit_select,
	input wire logic [5:0] fast_charge_current_code,
	input wire logic current_override_fifth,
	input wire logic [3:0] precharge_current_code,
	input wire logic [3:0] termination_current_code,
	input wire logic [5:0] charge_voltage_code,
	input wire logic fast_charge_entry_threshold,
	input wire logic recharge_threshold_select,
	input wire logic [12:0] minimum_system_mv,
	input wire logic [12:0] boost_limit_ma,
	input wire logic [12:0] programmed_charge_ma,
	input wire logic [12:0] effective_charge_ma,
	input wire logic [12:0] precharge_ma,
	input wire logic [12:0] termination_ma
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Decoded setpoints lag their fields by one cycle, so they are judged against $past
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	mode_charge_a: assert property (charge_enable == (operating_mode_select == 2'h1))
		else $error("charge enable does not follow mode");
	mode_boost_a: assert property (boost_enable == operating_mode_select[1])
		else $error("boost enable does not follow mode");
	sysmin_value_a: assert property ($past(rst_n) |->
		minimum_system_mv == 13'hBB8 + 13'h64 * 13'($past(minimum_system_voltage_code)))
		else $error("system minimum voltage decode wrong");
	boost_value_a: assert property ($past(rst_n) |->
		boost_limit_ma == ($past(boost_current_limit_select) ? 13'h514 : 13'h1F4))
		else $error("boost limit decode wrong");
	charge_value_a: assert property ($past(rst_n) |->
		programmed_charge_ma == 13'h200 + 13'h40 * 13'($past(fast_charge_current_code)))
		else $error("charge current decode wrong");
	fifth_value_a: assert property ($past(rst_n) |->
		effective_charge_ma == ($past(current_override_fifth) ? programmed_charge_ma / 13'h5 : programmed_charge_ma))
		else $error("override current wrong");
	pre_term_a: assert property ($past(rst_n) |->
		precharge_ma == 13'h80 * (13'($past(precharge_current_code)) + 13'h1)
		&& termination_ma == 13'h80 * (13'($past(termination_current_code)) + 13'h1))
		else $error("precharge or termination decode wrong");
	reset_first_a: assert property (disable iff (1'b0) !rst_n |=>
		{operating_mode_select, minimum_system_voltage_code, boost_current_limit_select} == 6'h1B
		&& {fast_charge_current_code, current_override_fifth} == 7'h30)
		else $error("first registers not at defaults in reset");
	reset_second_a: assert property (disable iff (1'b0) !rst_n |=>
		{precharge_current_code, termination_current_code} == 8'h11
		&& {charge_voltage_code, fast_charge_entry_threshold, recharge_threshold_select} == 8'hB2)
		else $error("later registers not at defaults in reset");
	reg_reset_a: assert property (register_reset_pulse |->
		{operating_mode_select, minimum_system_voltage_code, boost_current_limit_select} == 6'h1B
		&& {fast_charge_current_code, current_override_fifth} == 7'h30 ##1 !register_reset_pulse)
		else $error("register reset did not restore defaults once");
	kick_pulse_a: assert property (watchdog_kick |=> !watchdog_kick)
		else $error("watchdog kick longer than one cycle");
	host_drop_a: assert property ($fell(host_mode) |-> $past(watchdog_expired))
		else $error("host mode dropped without expiry");
	host_set_a: assert property (register_reset_pulse |-> host_mode)
		else $error("reset write did not enter host mode");
endmodule
bind ccr_charger_config_registers ccr_regs_checker ccr_regs_checker_i (.*);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the charger configuration register bank
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ccr_pkg::*;
	logic clk, rst_n, scl, sda_in, sda_pull, sda_out, sda_oe, watchdog_expired, got;
	logic host_mode, watchdog_kick, register_reset_pulse, charge_enable, boost_enable;
	logic boost_current_limit_select, current_override_fifth, fast_charge_entry_threshold, recharge_threshold_select;
	logic [1:0] operating_mode_select;
	logic [2:0] minimum_system_voltage_code, ra;
	logic [3:0] precharge_current_code, termination_current_code;
	logic [5:0] fast_charge_current_code, charge_voltage_code, acks;
	logic [7:0] got_byte;
	logic [12:0] minimum_system_mv, boost_limit_ma, programmed_charge_ma, effective_charge_ma, precharge_ma, termination_ma;
	logic [7:0] exp_q[$];
	logic [7:0] regs[4];
	int n_fail, num_checks, cycles, kicks, resets, k0;
	// Open drain with pull-up: low whenever either side pulls
	assign sda_in = !((sda_oe && !sda_out) || sda_pull);
	ccr_charger_config_registers ccr_charger_config_registers_i (.*);
	ccr_host_model ccr_host_model_i (.clk(clk), .sda(sda_in), .scl(scl), .sda_pull(sda_pull), .got(got),
		.got_byte(got_byte));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		kicks <= kicks + int'(watchdog_kick);
		resets <= resets + int'(register_reset_pulse);
		if (cycles == 60000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic check(input string what, input logic [12:0] exp, input logic [12:0] act);
		num_checks++;
		if (act !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, act);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Read results are matched against the oldest note
	// ------------------------------------------------------------
	always @(posedge got) begin
		if (exp_q.size() == 0) check("unexpected byte", 13'h1FFF, 13'(got_byte));
		else check("read byte", 13'(exp_q.pop_front()), 13'(got_byte));
	end
	task automatic check_fields();
		logic [12:0] prog;
		prog = 13'h200 + 13'h40 * 13'(regs[1][7:2]);
		check("mode", 13'(regs[0][5:4]), 13'(operating_mode_select));
		check("charge enable", 13'(regs[0][5:4] == 2'h1), 13'(charge_enable));
		check("boost enable", 13'(regs[0][5]), 13'(boost_enable));
		check("sysmin mv", 13'hBB8 + 13'h64 * 13'(regs[0][3:1]), minimum_system_mv);
		check("boost ma", regs[0][0] ? 13'h514 : 13'h1F4, boost_limit_ma);
		check("charge ma", prog, programmed_charge_ma);
		check("effective ma", regs[1][0] ? prog / 13'h5 : prog, effective_charge_ma);
		check("precharge ma", 13'h80 * (13'(regs[2][7:4]) + 13'h1), precharge_ma);
		check("term ma", 13'h80 * (13'(regs[2][3:0]) + 13'h1), termination_ma);
		check("voltage code", 13'(regs[3][7:2]), 13'(charge_voltage_code));
		check("thresholds", 13'(regs[3][1:0]), 13'({fast_charge_entry_threshold, recharge_threshold_select}));
	endtask
	task automatic read_all();
		for (int k = 0; k < 4; k++) exp_q.push_back(regs[k]);
		ccr_host_model_i.read_regs(8'h01, 4, ra);
		check("read acks", 13'h7, 13'(ra));
		check("notes left", 13'h0, 13'(exp_q.size()));
		check_fields();
	endtask
	initial begin
		rst_n = 1'b0;
		watchdog_expired = 1'b0;
		void'($urandom(14));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		regs = '{8'h1B, 8'h60, 8'h11, 8'hB2};
		read_all();
		check("host mode idle", 13'h0, 13'(host_mode));
		for (int i = 0; i < 8; i++) begin
			regs[0] = {2'h0, 2'(i), 4'($urandom)};
			regs[1] = 8'($urandom) & 8'hFD;
			if (i == 7) regs[1] = 8'hFD;
			regs[2] = 8'($urandom);
			regs[3] = 8'($urandom);
			ccr_host_model_i.write_regs(CCR_SLAVE_ADDR, 8'h01, 4, regs, acks);
			check("write acks", 13'h3F, 13'(acks));
			read_all();
			check("host mode set", 13'h1, 13'(host_mode));
		end
		k0 = kicks;
		ccr_host_model_i.write_regs(CCR_SLAVE_ADDR, 8'h01, 1, '{8'h40 | regs[0], 8'h0, 8'h0, 8'h0}, acks);
		check("kick pulses", 13'(k0 + 1), 13'(kicks));
		read_all();
		watchdog_expired = 1'b1;
		@(negedge clk) watchdog_expired = 1'b0;
		@(negedge clk);
		check("host mode dropped", 13'h0, 13'(host_mode));
		k0 = resets;
		ccr_host_model_i.write_regs(CCR_SLAVE_ADDR, 8'h01, 1, '{8'h80, 8'h0, 8'h0, 8'h0}, acks);
		check("reset pulses", 13'(k0 + 1), 13'(resets));
		check("host mode again", 13'h1, 13'(host_mode));
		regs = '{8'h1B, 8'h60, 8'h11, 8'hB2};
		read_all();
		ccr_host_model_i.write_regs(CCR_SLAVE_ADDR, 8'h04, 2, '{8'h5A, 8'hFF, 8'h0, 8'h0}, acks);
		check("past end acks", 13'h7, 13'(acks[3:0]));
		ccr_host_model_i.write_regs(CCR_SLAVE_ADDR ^ 7'h01, 8'h01, 1, '{8'h00, 8'h0, 8'h0, 8'h0}, acks);
		check("foreign address acks", 13'h0, 13'(acks[2:0]));
		exp_q.push_back(8'h00);
		ccr_host_model_i.read_regs(8'h05, 1, ra);
		check("unmapped acks", 13'h5, 13'(ra));
		regs[3] = 8'h5A;
		read_all();
		conclude();
	end
endmodule
`default_nettype wire

// ==== rtl/ccr_charger_config_registers.sv ====
// Charger configuration register bank behind an I2C slave
`default_nettype none
// Summary of operation
// - Register-reset bit restores defaults, self-clears
// - Watchdog-kick bit restarts watchdog, self-clears
// - Mode field: disabled, charge, or boost
// - System minimum voltage: 3.0 V plus weights
// - Boost limit bit: 500 mA or 1.3 A
// - Power-on configuration resets to 0x1B
// - Fast-charge current: 512 mA plus weights
// - Override bit selects 20% of charge current
// - Charge current register resets to 0x60
// - Precharge/termination: 128 mA plus weights
// - Precharge/termination register resets to 0x11
// - Charge voltage register fields, resets 0xB2
// - Any data write to a mapped register enters host-managed operation
module ccr_charger_config_registers #(
	parameter logic [6:0] SLAVE_ADDR = ccr_pkg::CCR_SLAVE_ADDR
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic watchdog_expired,
	output logic host_mode,
	output logic watchdog_kick,
	output logic register_reset_pulse,
	output logic [1:0] operating_mode_select,
	output logic charge_enable,
	output logic boost_enable,
	output logic [2:0] minimum_system_voltage_code,
	output logic boost_current_limit_select,
	output logic [5:0] fast_charge_current_code,
	output logic current_override_fifth,
	output logic [3:0] precharge_current_code,
	output logic [3:0] termination_current_code,
	output logic [5:0] charge_voltage_code,
	output logic fast_charge_entry_threshold,
	output logic recharge_threshold_select,
	output logic [12:0] minimum_system_mv,
	output logic [12:0] boost_limit_ma,
	output logic [12:0] programmed_charge_ma,
	output logic [12:0] effective_charge_ma,
	output logic [12:0] precharge_ma,
	output logic [12:0] termination_ma
);
	import ccr_pkg::*;

	typedef enum logic [3:0] {
		st_idle, st_addr, st_addr_ack, st_ptr, st_ptr_ack,
		st_wdata, st_wdata_ack, st_rdata, st_rdata_ack, st_wait
	} ccr_state_t;

	// ----------------------------------------------------------------
	// Register storage and read mux
	// ----------------------------------------------------------------
	logic [7:0] power_on_configuration;
	logic [7:0] fast_charge_current;
	logic [7:0] precharge_termination_current;
	logic [7:0] charge_voltage_control;

	function automatic logic [7:0] ccr_read(input logic [7:0] idx, input logic [7:0] r1, input logic [7:0] r2,
		input logic [7:0] r3, input logic [7:0] r4);
		logic [7:0] v;
		v = 8'h00;
		if (idx == CCR_OFS_POWER_ON) begin
			v = r1;
		end else if (idx == CCR_OFS_CHARGE_CURRENT) begin
			v = r2;
		end else if (idx == CCR_OFS_PRE_TERM) begin
			v = r3;
		end else if (idx == CCR_OFS_CHARGE_VOLTAGE) begin
			v = r4;
		end
		return v;
	endfunction

	function automatic logic ccr_mapped(input logic [7:0] idx);
		return (idx >= CCR_OFS_POWER_ON) && (idx <= CCR_OFS_CHARGE_VOLTAGE);
	endfunction

	// ----------------------------------------------------------------
	// Line sampling and bus conditions
	// ----------------------------------------------------------------
	logic scl_q;
	logic sda_q;
	wire logic scl_rise = scl & ~scl_q;
	wire logic scl_fall = ~scl & scl_q;
	wire logic bus_start = scl & scl_q & sda_q & ~sda_in;
	wire logic bus_stop = scl & scl_q & ~sda_q & sda_in;

	// ----------------------------------------------------------------
	// Serial engine state
	// ----------------------------------------------------------------
	ccr_state_t state;
	ccr_state_t next_state;
	logic [2:0] bit_cnt;
	logic [2:0] next_bit_cnt;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic byte_full;
	logic next_byte_full;
	logic rw;
	logic next_rw;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic [7:0] tx;
	logic [7:0] next_tx;
	logic oe;
	logic next_oe;
	logic mack;
	logic next_mack;
	logic wr_en;

	wire logic [7:0] rx_byte = shift;
	wire logic [7:0] ptr_inc = ptr + 8'h01;
	wire logic [7:0] rd_cur = ccr_read(ptr, power_on_configuration, fast_charge_current,
		precharge_termination_current, charge_voltage_control);
	wire logic [7:0] rd_inc = ccr_read(ptr_inc, power_on_configuration, fast_charge_current,
		precharge_termination_current, charge_voltage_control);
	wire logic addr_hit = (rx_byte[7:1] == SLAVE_ADDR);

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_byte_full = byte_full;
		next_rw = rw;
		next_ptr = ptr;
		next_tx = tx;
		next_oe = oe;
		next_mack = mack;
		wr_en = 1'b0;
		unique case (state)
			st_idle, st_wait: begin
				next_oe = 1'b0;
			end
			st_addr, st_ptr, st_wdata: begin
				if (scl_rise) begin
					next_shift = {shift[6:0], sda_in};
					next_bit_cnt = bit_cnt + 3'h1;
					next_byte_full = (bit_cnt == 3'h7);
				end else if (scl_fall && byte_full) begin
					next_byte_full = 1'b0;
					if (state == st_addr) begin
						next_rw = rx_byte[0];
						next_oe = addr_hit;
						next_state = addr_hit ? st_addr_ack : st_wait;
					end else if (state == st_ptr) begin
						// Unmapped pointer is refused with a NACK
						next_ptr = rx_byte;
						next_oe = ccr_mapped(rx_byte);
						next_state = ccr_mapped(rx_byte) ? st_ptr_ack : st_wait;
					end else begin
						wr_en = ccr_mapped(ptr);
						next_oe = ccr_mapped(ptr);
						next_state = ccr_mapped(ptr) ? st_wdata_ack : st_wait;
					end
				end
			end
			st_addr_ack: begin
				if (scl_fall) begin
					next_bit_cnt = 3'h0;
					if (rw) begin
						next_tx = rd_cur;
						next_oe = ~rd_cur[7];
						next_state = st_rdata;
					end else begin
						next_oe = 1'b0;
						next_state = st_ptr;
					end
				end
			end
			st_ptr_ack, st_wdata_ack: begin
				if (scl_fall) begin
					next_oe = 1'b0;
					next_bit_cnt = 3'h0;
					next_state = st_wdata;
					if (state == st_wdata_ack) begin
						next_ptr = ptr_inc;
					end
				end
			end
			st_rdata: begin
				if (scl_rise) begin
					next_bit_cnt = bit_cnt + 3'h1;
					next_byte_full = (bit_cnt == 3'h7);
				end else if (scl_fall) begin
					if (byte_full) begin
						next_byte_full = 1'b0;
						next_oe = 1'b0;
						next_state = st_rdata_ack;
					end else begin
						next_tx = {tx[6:0], 1'b0};
						next_oe = ~tx[6];
					end
				end
			end
			st_rdata_ack: begin
				if (scl_rise) begin
					next_mack = ~sda_in;
				end else if (scl_fall) begin
					next_bit_cnt = 3'h0;
					if (mack) begin
						// Multi-read walks forward through the map
						next_ptr = ptr_inc;
						next_tx = rd_inc;
						next_oe = ~rd_inc[7];
						next_state = st_rdata;
					end else begin
						next_oe = 1'b0;
						next_state = st_wait;
					end
				end
			end
		endcase
		if (bus_start) begin
			next_state = st_addr;
			next_bit_cnt = 3'h0;
			next_byte_full = 1'b0;
			next_oe = 1'b0;
		end else if (bus_stop) begin
			next_state = st_idle;
			next_oe = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			state <= st_idle;
			bit_cnt <= 3'h0;
			shift <= 8'h00;
			byte_full <= 1'b0;
			rw <= 1'b0;
			ptr <= 8'h00;
			tx <= 8'h00;
			oe <= 1'b0;
			mack <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda_in;
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			byte_full <= next_byte_full;
			rw <= next_rw;
			ptr <= next_ptr;
			tx <= next_tx;
			oe <= next_oe;
			mack <= next_mack;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = oe;

	// ----------------------------------------------------------------
	// Register writes and command bits
	// ----------------------------------------------------------------
	wire logic wr_poc = wr_en && (ptr == CCR_OFS_POWER_ON);
	wire logic do_reg_reset = wr_poc && rx_byte[CCR_BIT_REG_RESET];
	wire logic do_kick = wr_poc && rx_byte[CCR_BIT_WDOG_KICK];
	// Command bits are never stored, so they read back as zero
	wire logic [7:0] poc_store = rx_byte & 8'h3F;

	always_ff @(posedge clk) begin
		if (!rst_n || do_reg_reset) begin
			power_on_configuration <= CCR_RST_POWER_ON;
			fast_charge_current <= CCR_RST_CHARGE_CURRENT;
			precharge_termination_current <= CCR_RST_PRE_TERM;
			charge_voltage_control <= CCR_RST_CHARGE_VOLTAGE;
		end else if (wr_en) begin
			if (wr_poc) begin
				power_on_configuration <= poc_store;
			end
			// Reserved bit is stored as written; the host keeps it zero
			if (ptr == CCR_OFS_CHARGE_CURRENT) begin
				fast_charge_current <= rx_byte;
			end
			if (ptr == CCR_OFS_PRE_TERM) begin
				precharge_termination_current <= rx_byte;
			end
			if (ptr == CCR_OFS_CHARGE_VOLTAGE) begin
				charge_voltage_control <= rx_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// Host-managed operation and command pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			host_mode <= 1'b0;
			watchdog_kick <= 1'b0;
			register_reset_pulse <= 1'b0;
		end else begin
			// A write in the expiry cycle keeps host mode: set beats clear
			host_mode <= wr_en | (host_mode & ~watchdog_expired);
			watchdog_kick <= do_kick;
			register_reset_pulse <= do_reg_reset;
		end
	end

	// ----------------------------------------------------------------
	// Field outputs
	// ----------------------------------------------------------------
	assign operating_mode_select = power_on_configuration[CCR_MODE_HI:CCR_MODE_LO];
	assign charge_enable = (operating_mode_select == CCR_MODE_CHARGE);
	assign boost_enable = operating_mode_select[1];
	assign minimum_system_voltage_code = power_on_configuration[CCR_SYSMIN_HI:CCR_SYSMIN_LO];
	assign boost_current_limit_select = power_on_configuration[CCR_BIT_BOOST_SEL];
	assign fast_charge_current_code = fast_charge_current[CCR_FCC_HI:CCR_FCC_LO];
	assign current_override_fifth = fast_charge_current[CCR_BIT_FIFTH];
	assign precharge_current_code = precharge_termination_current[CCR_PRE_HI:CCR_PRE_LO];
	assign termination_current_code = precharge_termination_current[CCR_TERM_HI:CCR_TERM_LO];
	assign charge_voltage_code = charge_voltage_control[CCR_CVC_HI:CCR_CVC_LO];
	assign fast_charge_entry_threshold = charge_voltage_control[CCR_BIT_FAST_ENTRY];
	assign recharge_threshold_select = charge_voltage_control[CCR_BIT_RECHARGE];

	ccr_setpoint_decode u_decode (
		.clk(clk),
		.rst_n(rst_n),
		.minimum_system_voltage_code(minimum_system_voltage_code),
		.boost_current_limit_select(boost_current_limit_select),
		.fast_charge_current_code(fast_charge_current_code),
		.current_override_fifth(current_override_fifth),
		.precharge_current_code(precharge_current_code),
		.termination_current_code(termination_current_code),
		.minimum_system_mv(minimum_system_mv),
		.boost_limit_ma(boost_limit_ma),
		.programmed_charge_ma(programmed_charge_ma),
		.effective_charge_ma(effective_charge_ma),
		.precharge_ma(precharge_ma),
		.termination_ma(termination_ma)
	);
endmodule
`default_nettype wire

// ==== rtl/ccr_pkg.sv ====
// Constants shared by the charger configuration register bank
`default_nettype none
package ccr_pkg;
	// ----------------------------------------------------------------
	// Bus and address
	// ----------------------------------------------------------------
	localparam int CCR_DW = 8;
	localparam logic [6:0] CCR_SLAVE_ADDR = 7'h6B;
	localparam logic [7:0] CCR_OFS_POWER_ON = 8'h01;
	localparam logic [7:0] CCR_OFS_CHARGE_CURRENT = 8'h02;
	localparam logic [7:0] CCR_OFS_PRE_TERM = 8'h03;
	localparam logic [7:0] CCR_OFS_CHARGE_VOLTAGE = 8'h04;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CCR_RST_POWER_ON = 8'h1B;
	localparam logic [7:0] CCR_RST_CHARGE_CURRENT = 8'h60;
	localparam logic [7:0] CCR_RST_PRE_TERM = 8'h11;
	localparam logic [7:0] CCR_RST_CHARGE_VOLTAGE = 8'hB2;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CCR_BIT_REG_RESET = 7;
	localparam int CCR_BIT_WDOG_KICK = 6;
	localparam int CCR_MODE_HI = 5;
	localparam int CCR_MODE_LO = 4;
	localparam int CCR_SYSMIN_HI = 3;
	localparam int CCR_SYSMIN_LO = 1;
	localparam int CCR_BIT_BOOST_SEL = 0;
	localparam int CCR_FCC_HI = 7;
	localparam int CCR_FCC_LO = 2;
	localparam int CCR_BIT_RESERVED = 1;
	localparam int CCR_BIT_FIFTH = 0;
	localparam int CCR_PRE_HI = 7;
	localparam int CCR_PRE_LO = 4;
	localparam int CCR_TERM_HI = 3;
	localparam int CCR_TERM_LO = 0;
	localparam int CCR_CVC_HI = 7;
	localparam int CCR_CVC_LO = 2;
	localparam int CCR_BIT_FAST_ENTRY = 1;
	localparam int CCR_BIT_RECHARGE = 0;
	// ----------------------------------------------------------------
	// Operating modes and code scaling
	// ----------------------------------------------------------------
	localparam logic [1:0] CCR_MODE_DISABLED = 2'h0;
	localparam logic [1:0] CCR_MODE_CHARGE = 2'h1;
	localparam logic [12:0] CCR_SYSMIN_BASE_MV = 13'h0BB8;
	localparam logic [12:0] CCR_SYSMIN_STEP_MV = 13'h0064;
	localparam logic [12:0] CCR_FCC_BASE_MA = 13'h0200;
	localparam logic [12:0] CCR_FCC_STEP_MA = 13'h0040;
	localparam logic [12:0] CCR_PRE_TERM_BASE_MA = 13'h0080;
	localparam logic [12:0] CCR_PRE_TERM_STEP_MA = 13'h0080;
	localparam logic [12:0] CCR_BOOST_LOW_MA = 13'h01F4;
	localparam logic [12:0] CCR_BOOST_HIGH_MA = 13'h0514;
	localparam logic [12:0] CCR_FIFTH_DIVISOR = 13'h0005;
endpackage
`default_nettype wire

// ==== rtl/ccr_setpoint_decode.sv ====
// Turns the stored codes into physical setpoints for the analog side
`default_nettype none
module ccr_setpoint_decode (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] minimum_system_voltage_code,
	input wire logic boost_current_limit_select,
	input wire logic [5:0] fast_charge_current_code,
	input wire logic current_override_fifth,
	input wire logic [3:0] precharge_current_code,
	input wire logic [3:0] termination_current_code,
	output logic [12:0] minimum_system_mv,
	output logic [12:0] boost_limit_ma,
	output logic [12:0] programmed_charge_ma,
	output logic [12:0] effective_charge_ma,
	output logic [12:0] precharge_ma,
	output logic [12:0] termination_ma
);
	import ccr_pkg::*;
	// ----------------------------------------------------------------
	// Offset plus binary weights, plus the boost limit select and the fifth divide
	// ----------------------------------------------------------------
	wire logic [12:0] sysmin_mv = CCR_SYSMIN_BASE_MV + 13'({10'h000, minimum_system_voltage_code} * CCR_SYSMIN_STEP_MV);
	wire logic [12:0] boost_ma = boost_current_limit_select ? CCR_BOOST_HIGH_MA : CCR_BOOST_LOW_MA;
	wire logic [12:0] fcc_ma = CCR_FCC_BASE_MA + 13'({7'h00, fast_charge_current_code} * CCR_FCC_STEP_MA);
	// Constant divide truncates the fifth down to whole mA; a shift-add would drift
	wire logic [12:0] fcc_fifth_ma = fcc_ma / CCR_FIFTH_DIVISOR;
	wire logic [12:0] fcc_eff_ma = current_override_fifth ? fcc_fifth_ma : fcc_ma;
	wire logic [12:0] pre_ma = CCR_PRE_TERM_BASE_MA + 13'({9'h000, precharge_current_code} * CCR_PRE_TERM_STEP_MA);
	wire logic [12:0] term_ma = CCR_PRE_TERM_BASE_MA + 13'({9'h000, termination_current_code} * CCR_PRE_TERM_STEP_MA);

	// ----------------------------------------------------------------
	// Registered setpoints
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			minimum_system_mv <= 13'h0000;
			boost_limit_ma <= 13'h0000;
			programmed_charge_ma <= 13'h0000;
			effective_charge_ma <= 13'h0000;
			precharge_ma <= 13'h0000;
			termination_ma <= 13'h0000;
		end else begin
			minimum_system_mv <= sysmin_mv;
			boost_limit_ma <= boost_ma;
			programmed_charge_ma <= fcc_ma;
			effective_charge_ma <= fcc_eff_ma;
			precharge_ma <= pre_ma;
			termination_ma <= term_ma;
		end
	end
endmodule
`default_nettype wire
